// *** common/tctm_pkg.sv ***
// Purpose: constants and carrier types of the three channel timer core
// Assumes: AHB-Lite word access, one 25 MHz clock (hclk)
// Notes:   offsets are byte addresses, one aligned word per register
//
// Behaviour
// (R1) ch0 flag C sets on C match/capture
// (R2) flag C reads 0 on ch1, ch2
// (R3) read-1-then-write-0 clears flag; reset 0
// (R4) flag B sets on B match/capture
// (R5) flag A sets on A match/capture
// (R6) dma completion also clears flag A
// (R7) three 16-bit software read/write counters
// (R8) counters zero on reset and standby
// (R9) software accesses counters as words only
// (R10) ch0 counts up; ch1/2 may count down
// (R11) eight 16-bit compare/capture registers per layout
// (R12) ch0 C buffers A, D buffers B
// (R13) general registers all ones on reset/standby
// (R14) software accesses general registers as words
// (R15) run bit halts or runs its counter
// (R16) stopping keeps compare pin level
// (R17) io control write while stopped loads pin
// (R18) run bits 7 to 3 read 0
// (R19) writing 1 to flags does nothing
// (R20) flag A with enable raises interrupt
// (R21) zero write without prior read keeps flag
// (R22) set wins over simultaneous clear
package tctm_pkg;

  localparam int NCH = 3;                    // channels
  localparam int NGR = 8;                    // general registers

  // register byte offsets
  localparam logic [7:0] OFS_CNT0  = 8'h00;  // counter n at +4n
  localparam logic [7:0] OFS_GREG0 = 8'h10;  // general reg i at +4i
  localparam logic [7:0] OFS_RUN   = 8'h30;  // run control
  localparam logic [7:0] OFS_STAT0 = 8'h34;  // status n at +4n
  localparam logic [7:0] OFS_IOC0  = 8'h40;  // io control n at +4n

  // reset values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] GREG_RST = 16'hffff;

  // io control fields: bits 3..0 pick capture per slot
  localparam int IOC_INIT = 4;               // initial pin level
  localparam int IOC_BUF  = 5;               // ch0 buffer pairing
  localparam int IOC_IRQA = 6;               // flag a irq enable
  localparam int IOC_DOWN = 7;               // ch1/2 count down
  localparam logic [7:0] IOC_MASK0  = 8'h7f; // writable bits ch0
  localparam logic [7:0] IOC_MASK12 = 8'hd3; // writable bits ch1/2

  // status fields
  localparam int STAT_A = 0;
  localparam int STAT_B = 1;
  localparam int STAT_C = 2;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // channel that owns general register i
  function automatic int greg_ch(int i);
    return (i < 4) ? 0 : ((i < 6) ? 1 : 2);
  endfunction : greg_ch

  // slot a/b/c/d of general register i within its channel
  function automatic int greg_slot(int i);
    return (i < 4) ? i : ((i - 4) % 2);
  endfunction : greg_slot

  // ahb-lite request side
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } tctm_ahb_req_t;

  // timer side events, one-cycle pulses
  typedef struct packed {
    logic [NCH-1:0] tick;                    // counter clock per channel
    logic [NGR-1:0] cap;                     // capture strobe per reg
    logic [NCH-1:0] dma_done_a;              // dma served flag a
  } tctm_evt_t;

  // whole state of the core
  typedef struct packed {
    logic [NCH-1:0][15:0] cnt;
    logic [NGR-1:0][15:0] greg;
    logic [NCH-1:0]       run;
    logic [NCH-1:0][2:0]  flag;
    logic [NCH-1:0][2:0]  armed;             // flag seen as 1 by read
    logic [NCH-1:0][7:0]  ioc;
    logic [NCH-1:0]       pin;
    logic                 wr_pend;           // write data phase due
    logic                 wr_word;
    logic [7:0]           wr_addr;
    logic [31:0]          rdata;
  } tctm_state_t;

  localparam tctm_state_t ST_RST = '{greg: {NGR{GREG_RST}}, default: '0};

endpackage : tctm_pkg

// *** design/tctm_core.sv ***
// Purpose: three channel 16-bit timer core with ahb-lite registers
// Assumes: prescaled count ticks and capture strobes arrive as pulses
// Notes:   zero wait state slave, read data registered in address phase
`timescale 1ns/1ns
module tctm_core (
  input  wire logic                   hclk,           // bus clock
  input  wire logic                   hresetn,        // async reset, low
  input  wire tctm_pkg::tctm_ahb_req_t ahb_req,       // ahb request
  output logic [31:0]                 hrdata,         // read data
  output logic                        hreadyout,      // always ready
  output logic                        hresp,          // always okay
  input  wire tctm_pkg::tctm_evt_t    evt,            // timer events
  input  wire logic                   standby,        // standby clear
  output logic [2:0]                  compare_io_pin, // compare outputs
  output logic [2:0]                  match_irq_a     // flag a requests
);
  import tctm_pkg::*;

  tctm_state_t    st_reg;                    // registered state
  tctm_state_t    st_next;                   // next state
  logic           acc;                       // address phase taken
  logic [NGR-1:0] cap_ev;                    // capture into reg i
  logic [NGR-1:0] cmp_ev;                    // compare match reg i
  logic [NGR-1:0] ev_any;                    // either event
  logic [NCH-1:0][2:0] flag_set;             // flag set causes

  assign acc = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];

  // per register match and capture events
  for (genvar i = 0; i < NGR; i++)
  begin : g_ev
    localparam int CH = greg_ch(i);
    localparam int SL = greg_slot(i);
    logic buffered;                          // c/d acting as buffer
    assign buffered = (CH == 0) && (SL >= 2) && st_reg.ioc[0][IOC_BUF];
    assign cap_ev[i] = evt.cap[i] & st_reg.ioc[CH][SL] & ~buffered;
    assign cmp_ev[i] = evt.tick[CH] & st_reg.run[CH] & ~st_reg.ioc[CH][SL]
                       & (st_reg.cnt[CH] == st_reg.greg[i]) & ~buffered;
    assign ev_any[i] = cap_ev[i] | cmp_ev[i];
  end

  // flag set sources; slot d has no flag here
  assign flag_set[0] = {ev_any[2], ev_any[1], ev_any[0]}; // [R1] [R4] [R5]
  assign flag_set[1] = {1'b0, ev_any[5], ev_any[4]};      // [R2]
  assign flag_set[2] = {1'b0, ev_any[7], ev_any[6]};      // [R2]

  // next state of the whole core
  always_comb
  begin
    logic [7:0]         a;                   // address phase offset
    logic [7:0]         wa;                  // data phase offset
    logic [31:0]        wd;                  // write data
    logic [NCH-1:0][2:0] clr;                // flag clear requests
    a   = ahb_req.haddr[7:0];
    wa  = st_reg.wr_addr;
    wd  = ahb_req.hwdata;
    clr = '0;
    st_next = st_reg;
    st_next.wr_pend = 1'b0;

    // counting while run bit is set
    for (int c = 0; c < NCH; c++)
    begin
      if (st_reg.run[c] && evt.tick[c])      // [R15]
      begin
        if (c != 0 && st_reg.ioc[c][IOC_DOWN])
          st_next.cnt[c] = st_reg.cnt[c] - 16'h0001;  // [R10]
        else
          st_next.cnt[c] = st_reg.cnt[c] + 16'h0001;  // [R10]
      end
    end

    // capture loads the counter value
    for (int i = 0; i < NGR; i++)
    begin
      if (cap_ev[i])
        st_next.greg[i] = st_reg.cnt[greg_ch(i)];     // [R11]
    end

    // ch0 buffer pairing a-c, b-d
    for (int i = 0; i < 2; i++)
    begin
      if (st_reg.ioc[0][IOC_BUF])
      begin
        if (cap_ev[i])
          st_next.greg[i+2] = st_reg.greg[i];         // [R12]
        else if (cmp_ev[i])
          st_next.greg[i] = st_reg.greg[i+2];         // [R12]
      end
    end

    // a match toggles the pin; idle channel holds it
    for (int c = 0; c < NCH; c++)
    begin
      if (cmp_ev[(c == 0) ? 0 : 2 + 2 * c])
        st_next.pin[c] = ~st_reg.pin[c];              // [R16]
    end

    // dma service clears flag a
    for (int c = 0; c < NCH; c++)
      clr[c][STAT_A] = evt.dma_done_a[c];             // [R6]

    // write data phase
    if (st_reg.wr_pend)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // counters take whole words only
        if (wa == OFS_CNT0 + 8'(4 * c) && st_reg.wr_word)
          st_next.cnt[c] = wd[15:0];                  // [R7] [R9]
        // status: only a zero on an armed flag clears
        if (wa == OFS_STAT0 + 8'(4 * c))
        begin
          clr[c] = clr[c] | (~wd[2:0] & st_reg.armed[c]); // [R3] [R19] [R21]
          st_next.armed[c] = 3'h0;
        end
        // io control; stopped channel reloads its pin
        if (wa == OFS_IOC0 + 8'(4 * c))
        begin
          st_next.ioc[c] = wd[7:0] & ((c == 0) ? IOC_MASK0 : IOC_MASK12);
          if (!st_reg.run[c])
            st_next.pin[c] = wd[IOC_INIT];            // [R17]
        end
      end
      for (int i = 0; i < NGR; i++)
      begin
        if (wa == OFS_GREG0 + 8'(4 * i) && st_reg.wr_word)
          st_next.greg[i] = wd[15:0];                 // [R11] [R14]
      end
      if (wa == OFS_RUN)
        st_next.run = wd[2:0];                        // [R15]
    end

    // flags: set wins over clear
    for (int c = 0; c < NCH; c++)
      st_next.flag[c] = (st_reg.flag[c] & ~clr[c]) | flag_set[c]; // [R22]

    // address phase
    if (acc)
    begin
      if (ahb_req.hwrite)
      begin
        st_next.wr_pend = 1'b1;
        st_next.wr_addr = a;
        st_next.wr_word = (ahb_req.hsize == HSIZE_WORD);
      end
      else
      begin
        st_next.rdata = 32'h0;               // unmapped reads zero
        for (int c = 0; c < NCH; c++)
        begin
          if (a == OFS_CNT0 + 8'(4 * c))
            st_next.rdata = {16'h0, st_reg.cnt[c]};   // [R7]
          if (a == OFS_IOC0 + 8'(4 * c))
            st_next.rdata = {24'h0, st_reg.ioc[c]};
          if (a == OFS_STAT0 + 8'(4 * c))
          begin
            // bit 7 count direction, bit 6 fixed one
            st_next.rdata = {24'h0,
              (c == 0) ? 1'b1 : ~st_reg.ioc[c][IOC_DOWN],
              1'b1, 3'h0, st_reg.flag[c]};            // [R2]
            st_next.armed[c] = st_reg.flag[c];        // [R3]
          end
        end
        for (int i = 0; i < NGR; i++)
        begin
          if (a == OFS_GREG0 + 8'(4 * i))
            st_next.rdata = {16'h0, st_reg.greg[i]};
        end
        if (a == OFS_RUN)
          st_next.rdata = {29'h0, st_reg.run};        // [R18]
      end
    end

    // standby returns everything to reset values
    if (standby)
      st_next = ST_RST;                               // [R8] [R13]
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_reg <= ST_RST;                               // [R3] [R8] [R13]
    else
      st_reg <= st_next;
  end

  // outputs
  assign hrdata         = st_reg.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign compare_io_pin = st_reg.pin;
  for (genvar c = 0; c < NCH; c++)
  begin : g_irq
    assign match_irq_a[c] = st_reg.flag[c][STAT_A]
                            & st_reg.ioc[c][IOC_IRQA]; // [R20]
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_run_s;
    acc && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFS_RUN;
  endsequence

  sequence wr0_armed_a_s;
    st_reg.wr_pend && st_reg.wr_addr == OFS_STAT0 && !ahb_req.hwdata[0]
      && st_reg.armed[0][0];
  endsequence

  sequence quiet_ch0_s;
    !standby && !st_reg.wr_pend;
  endsequence

  flag_c_zero_a: assert property (                    // [R2]
    st_reg.flag[1][2] == 1'b0 && st_reg.flag[2][2] == 1'b0)
    else $error("flag c set on channel 1 or 2");

  run_read_a: assert property (                       // [R18]
    rd_run_s |=> hrdata[7:3] == 5'h0 && hrdata[2:0] == $past(st_reg.run))
    else $error("run control read wrong");

  clear_armed_a: assert property (                    // [R3]
    wr0_armed_a_s and (!flag_set[0][0] && !standby) |=> !st_reg.flag[0][0])
    else $error("armed zero write did not clear flag a");

  keep_unarmed_a: assert property (                   // [R21]
    st_reg.flag[0][0] && !st_reg.armed[0][0] && !evt.dma_done_a[0]
      && !standby |=> st_reg.flag[0][0])
    else $error("flag a cleared without prior read");

  set_wins_a: assert property (                       // [R22]
    flag_set[0][0] && !standby |=> st_reg.flag[0][0])
    else $error("set lost against clear");

  dma_clear_a: assert property (                      // [R6]
    evt.dma_done_a[0] && !flag_set[0][0] && !standby |=> !st_reg.flag[0][0])
    else $error("dma completion left flag a set");

  no_spurious_a: assert property (                    // [R19]
    !st_reg.flag[0][1] && !flag_set[0][1] |=> !st_reg.flag[0][1])
    else $error("flag b set without cause");

  count_up_a: assert property (                       // [R10]
    (st_reg.run[0] && evt.tick[0]) and quiet_ch0_s
      |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) + 16'h0001)
    else $error("channel 0 did not count up");

  halt_a: assert property (                           // [R15]
    (!st_reg.run[2]) and quiet_ch0_s |=> $stable(st_reg.cnt[2]))
    else $error("halted counter moved");

  standby_a: assert property (                        // [R8] [R13]
    standby |=> st_reg.cnt == '0 && st_reg.greg == {NGR{GREG_RST}}
      && st_reg.run == 3'h0)
    else $error("standby did not restore reset values");

  pin_init_a: assert property (                       // [R17]
    st_reg.wr_pend && st_reg.wr_addr == OFS_IOC0 && !st_reg.run[0]
      && !standby |=> compare_io_pin[0] == $past(ahb_req.hwdata[IOC_INIT]))
    else $error("pin not loaded with initial level");

  irq_follow_a: assert property (                     // [R20]
    ev_any[0] && st_reg.ioc[0][IOC_IRQA] && !standby && !st_reg.wr_pend
      |=> match_irq_a[0])
    else $error("interrupt request missing");

  match_c_a: assert property (                        // [R1]
    cmp_ev[2] && !standby |=> st_reg.flag[0][2])
    else $error("flag c not set on match");

  match_b_a: assert property (                        // [R4]
    ev_any[1] && !standby |=> st_reg.flag[0][1])
    else $error("flag b not set on event");

  match_ch1_a: assert property (                      // [R5]
    ev_any[4] && !standby |=> st_reg.flag[1][0])
    else $error("channel 1 flag a not set on event");

  capture_load_a: assert property (                   // [R11]
    cap_ev[4] && !standby && !st_reg.wr_pend
      |=> st_reg.greg[4] == $past(st_reg.cnt[1]))
    else $error("capture did not load the counter");

  buffer_cap_a: assert property (                     // [R12]
    st_reg.ioc[0][IOC_BUF] && cap_ev[0] && !standby && !st_reg.wr_pend
      |=> st_reg.greg[2] == $past(st_reg.greg[0]))
    else $error("buffered capture did not move a into c");

  buffer_cmp_a: assert property (                     // [R12]
    st_reg.ioc[0][IOC_BUF] && cmp_ev[0] && !standby && !st_reg.wr_pend
      |=> st_reg.greg[0] == $past(st_reg.greg[2]))
    else $error("buffered match did not move c into a");

  pin_hold_a: assert property (                       // [R16]
    !st_reg.run[0] && !standby && !st_reg.wr_pend
      |=> $stable(compare_io_pin[0]))
    else $error("stopped channel changed its pin");

  write_word_a: assert property (                     // [R7]
    st_reg.wr_pend && st_reg.wr_word && st_reg.wr_addr == OFS_CNT0
      && !standby |=> st_reg.cnt[0] == $past(ahb_req.hwdata[15:0]))
    else $error("word write did not reach the counter");

endmodule : tctm_core

// *** tb/tctm_core_test.sv ***
// Purpose: self-checking bench of the three channel timer core
// Assumes: zero wait state slave, timer events as one-cycle pulses
// Notes:   random data from a fixed seed, corner cases by hand
`timescale 1ns/1ns
module tctm_core_test;
  import tctm_pkg::*;
  logic          hclk;       // bus clock
  logic          hresetn;    // reset, low
  logic          hsel;       // slave select
  logic [31:0]   haddr;      // byte address
  logic [1:0]    htrans;     // transfer kind
  logic          hwrite;     // write strobe
  logic [2:0]    hsize;      // transfer size
  logic [31:0]   hwdata;     // write data
  logic [31:0]   hrdata;     // read data
  logic          hreadyout;  // slave ready, bus hready
  logic          hresp;      // slave response
  tctm_ahb_req_t ahb_req;    // packed request
  tctm_evt_t     evt;        // timer events
  logic          standby;    // standby clear
  logic [2:0]    pin;        // compare outputs
  logic [2:0]    irq;        // flag a requests
  int            n_mismatch; // mismatches
  int            n_checks;   // comparisons
  logic [31:0]   rd;         // last read data
  logic [15:0]   v;          // random value
  logic [15:0]   w;          // random value
  logic [7:0]    a;          // register address

  // one slave only, so its ready is the bus ready
  assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hwdata, hreadyout};

  tctm_core u_dut (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .ahb_req        (ahb_req),
    .hrdata         (hrdata),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .evt            (evt),
    .standby        (standby),
    .compare_io_pin (pin),
    .match_irq_a    (irq)
  );

  // 25 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // verdict and end of run
  task automatic final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : final_report

  // hang guard, far beyond the expected run
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask : chk

  // register address from base and index
  function automatic logic [7:0] adr(input logic [7:0] b, input int i);
    return b + 8'(4 * i);
  endfunction : adr

  // expected status word: direction, fixed one, flags
  function automatic logic [31:0] stat_exp(input logic [2:0] f,
                                           input logic up);
    return {24'h0, up, 1'b1, 3'h0, f};
  endfunction : stat_exp

  // next edge with hready high, bounded
  task automatic wait_rdy;
    begin
      @(posedge hclk);
      for (int n = 0; n < 64 && hreadyout !== 1'b1; n++)
        @(posedge hclk);
      if (hreadyout !== 1'b1)
        n_mismatch++;                  // wait limit ran out
    end
  endtask : wait_rdy

  // single transfer; read data taken at the data phase edge
  task automatic bus(input logic wr_en, input logic [7:0] ad,
                     input logic [31:0] d, input logic [2:0] sz);
    begin
      haddr  <= {24'h0, ad};
      htrans <= 2'h2;
      hwrite <= wr_en;
      hsize  <= sz;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
    end
  endtask : bus

  // word write
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, HSIZE_WORD);
  endtask : wr

  // word read and compare
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    begin
      bus(1'b0, ad, 32'h0, HSIZE_WORD);
      chk(rd, e);
    end
  endtask : rdc

  // pins, irqs, ready and okay sampled mid cycle, where settled
  task automatic chk_out(input logic [2:0] p, input logic [2:0] q);
    begin
      @(negedge hclk);
      chk({24'h0, hreadyout, hresp, pin, irq}, {24'h0, 2'h2, p, q});
      @(posedge hclk);
    end
  endtask : chk_out

  // one-cycle event pulse
  task automatic pulse(input tctm_evt_t e);
    begin
      evt <= e;
      @(posedge hclk);
      evt <= '0;
      @(posedge hclk);
    end
  endtask : pulse

  // reset image of every register except io control, plus pins and irqs
  task automatic check_rst;
    begin
      for (int c = 0; c < NCH; c++)
      begin
        rdc(adr(OFS_CNT0, c), 32'h0);
        rdc(adr(OFS_STAT0, c), stat_exp(3'h0, 1'b1));
      end
      for (int i = 0; i < NGR; i++)
        rdc(adr(OFS_GREG0, i), {16'h0, GREG_RST});
      rdc(OFS_RUN, 32'h0);
      chk_out(3'h0, 3'h0);
    end
  endtask : check_rst

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    evt = '0;
    standby = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h762c));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_rst();
    // word round trip, then a halfword write that must be ignored
    for (int i = 0; i < NCH + NGR; i++)
    begin
      a = (i < NCH) ? adr(OFS_CNT0, i) : adr(OFS_GREG0, i - NCH);
      v = 16'($urandom);
      wr(a, {16'h0, v});
      rdc(a, {16'h0, v});
      bus(1'b1, a, {16'h0, ~v}, 3'h1);
      rdc(a, {16'h0, v});
    end
    wr(OFS_RUN, 32'hff);
    rdc(OFS_RUN, 32'h7);
    rdc(8'hfc, 32'h0);
    wr(OFS_RUN, 32'h0);
    // compare match of a, b and c in one tick, d one off
    v = 16'($urandom);
    wr(adr(OFS_IOC0, 0), 32'h40);
    wr(OFS_CNT0, {16'h0, v});
    for (int i = 0; i < 4; i++)
      wr(adr(OFS_GREG0, i), {16'h0, v + 16'(i / 3)});
    wr(OFS_RUN, 32'h1);
    pulse('{tick: 3'h1, default: '0});
    rdc(OFS_CNT0, {16'h0, v + 16'h1});
    chk_out(3'h1, 3'h1);
    wr(OFS_RUN, 32'h0);
    pulse('{tick: 3'h1, default: '0});
    rdc(OFS_CNT0, {16'h0, v + 16'h1});
    chk_out(3'h1, 3'h1);
    // read arms; a 1 write and an unarmed 0 write change nothing
    rdc(OFS_STAT0, stat_exp(3'h7, 1'b1));
    wr(OFS_STAT0, 32'hff);
    wr(OFS_STAT0, 32'h0);
    rdc(OFS_STAT0, stat_exp(3'h7, 1'b1));
    wr(OFS_STAT0, 32'h6);
    rdc(OFS_STAT0, stat_exp(3'h6, 1'b1));
    chk_out(3'h1, 3'h0);
    wr(OFS_STAT0, 32'h0);
    rdc(OFS_STAT0, stat_exp(3'h0, 1'b1));
    wr(adr(OFS_IOC0, 0), 32'h07);
    chk_out(3'h0, 3'h0);
    // captures, set against dma clear, then dma clear alone
    v = 16'($urandom);
    wr(OFS_CNT0, {16'h0, v});
    pulse('{cap: 8'h07, default: '0});
    rdc(adr(OFS_GREG0, 2), {16'h0, v});
    pulse('{cap: 8'h01, dma_done_a: 3'h1, default: '0});
    rdc(OFS_STAT0, stat_exp(3'h7, 1'b1));
    pulse('{dma_done_a: 3'h1, default: '0});
    rdc(OFS_STAT0, stat_exp(3'h6, 1'b1));
    // buffered capture: old a moves into c
    wr(adr(OFS_IOC0, 0), 32'h21);
    w = 16'($urandom);
    wr(OFS_GREG0, {16'h0, w});
    pulse('{cap: 8'h01, default: '0});
    rdc(adr(OFS_GREG0, 2), {16'h0, w});
    rdc(OFS_GREG0, {16'h0, v});
    // buffered compare: c moves into a on a match
    wr(adr(OFS_IOC0, 0), 32'h20);
    wr(OFS_RUN, 32'h1);
    pulse('{tick: 3'h1, default: '0});
    rdc(OFS_GREG0, {16'h0, w});
    // channel 1: captures a and b, flag c stays 0, counts down
    wr(adr(OFS_IOC0, 1), 32'h83);
    wr(adr(OFS_CNT0, 1), 32'h0);
    pulse('{cap: 8'h30, default: '0});
    rdc(adr(OFS_STAT0, 1), stat_exp(3'h3, 1'b0));
    wr(OFS_RUN, 32'h2);
    pulse('{tick: 3'h2, default: '0});
    rdc(adr(OFS_CNT0, 1), 32'hffff);
    // standby returns everything to reset values
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    @(posedge hclk);
    check_rst();
    final_report();
  end
endmodule : tctm_core_test
